// file: src/msl_link_config.sv
// Purpose: Station address, framing, link-loss and reply-delay supervision of a Modbus slave
// Assumes: Received characters arrive decoded, on hclk, from the serial receiver
// Notes: hresetn is the power cycle; setting storage survives it and is cleared by nv_rstn
//
// Added by the designer: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "msl_regs.svh"

// Contract
// - Station address 1..31, default one
// - Address zero: never send any reply
// - New settings apply after power cycle only
// - Codes 0..3 are RTU, 8 bits
// - Codes 4..11 are ASCII, 8/7 bits
// - Framing accepts 0..11, default code 1
// - Loss timeout 0..10 s, zero disables
// - Timeout expiry raises fault, selected action
// - Wait reply delay before reply starts
// - Broadcast to zero acted on, no reply
// - RTU CRC-16 seed FFFF, poly A001
// - ASCII colon start, CR LF end, hex
// - Support functions 03, 06, 08, 10
module msl_link_config #(
  parameter int TENTH_CYCLES = `MSL_TENTH_US * `MSL_CLK_MHZ,
  parameter int MS_CYCLES = `MSL_MS_US * `MSL_CLK_MHZ
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic nv_rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic rx_valid,
  input wire logic [7:0] rx_char,
  input wire logic rx_err,
  input wire logic rx_gap,
  output logic [3:0] baud_sel,
  output logic ascii_mode,
  output logic seven_bits,
  output msl_pkg::msl_parity_t parity,
  output logic two_stop,
  output logic frame_good,
  output logic func_ok,
  output logic reply_go,
  output logic comm_fault,
  output logic [1:0] loss_action,
  output logic irq
);
  // Stored settings (survive power cycle) and their running copies
  logic [4:0] st_addr_q, act_addr_q;
  logic [3:0] st_baud_q, st_frm_q, act_frm_q;
  logic [6:0] st_tmo_q, act_tmo_q;
  logic [7:0] st_dly_q, act_dly_q;
  logic [1:0] st_act_q;
  logic loaded_q;
  logic [3:0] irq_st_q, irq_mask_q, ev;
  // Bus data phase
  logic wr_q, rd_q;
  logic [7:0] a_q;
  // Receiver
  msl_pkg::msl_rx_state_t rx_q;
  logic [15:0] crc_q;
  logic [7:0] lrc_q, byte_q, addr_q, fn_q, abyte;
  logic [4:0] hv;
  logic [5:0] cnt_q;
  logic nib_q, bad_q;
  logic end_p, end_ok;
  // Timers
  logic [31:0] tick_q, dtick_q;
  logic [6:0] tenth_q;
  logic [7:0] dms_q;
  logic dly_run_q;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `MSL_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
  // Hex character to nibble; bit 4 flags a non-hex character; either letter case is taken
  function automatic logic [4:0] hex_val(input logic [7:0] ch);
    if (ch >= 8'h30 && ch <= 8'h39) return {1'b0, ch[3:0]};
    if ((ch | 8'h20) >= 8'h61 && (ch | 8'h20) <= 8'h66) return {1'b0, ch[3:0] + 4'h9};
    return 5'h10;
  endfunction
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    case (a)
      `MSL_A_STATION: return {27'h0, st_addr_q};
      `MSL_A_BAUD: return {28'h0, st_baud_q};
      `MSL_A_FRAMING: return {28'h0, st_frm_q};
      `MSL_A_TIMEOUT: return {25'h0, st_tmo_q};
      `MSL_A_DELAY: return {24'h0, st_dly_q};
      `MSL_A_ACTION: return {30'h0, st_act_q};
      `MSL_A_ACTIVE: return {15'h0, comm_fault, act_frm_q, 7'h0, act_addr_q};
      `MSL_A_IRQ_ST: return {28'h0, irq_st_q};
      `MSL_A_IRQ_MASK: return {28'h0, irq_mask_q};
      default: return 32'h0000_0000;
    endcase
  endfunction
  // Address phase capture; reads take one wait state so a preceding write is seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      a_q <= 8'h00;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_q <= 1'b0;
      if (rd_q) begin
        rd_q <= 1'b0;
        hrdata <= rd_mux(a_q);
        hreadyout <= 1'b1;
      end else if (hready && hsel && htrans[1]) begin
        wr_q <= hwrite;
        rd_q <= !hwrite;
        a_q <= haddr[7:0];
        hreadyout <= hwrite;
      end
    end
  end
  assign hresp = 1'b0;

  // Stored settings; out-of-range station, framing and timeout values are refused and the old value kept; baud, delay and action take the low bits
  always_ff @(posedge hclk or negedge nv_rstn) begin
    if (!nv_rstn) begin
      st_addr_q <= `MSL_RST_STATION;
      st_baud_q <= `MSL_RST_BAUD;
      st_frm_q <= `MSL_RST_FRAMING;
      st_tmo_q <= `MSL_RST_TIMEOUT;
      st_dly_q <= `MSL_RST_DELAY;
      st_act_q <= `MSL_RST_ACTION;
    end else if (wr_q) begin
      if (a_q == `MSL_A_STATION && hwdata[31:5] == 27'h0) st_addr_q <= hwdata[4:0];
      if (a_q == `MSL_A_BAUD) st_baud_q <= hwdata[3:0];
      if (a_q == `MSL_A_FRAMING && hwdata[31:4] == 28'h0 && hwdata[3:0] <= `MSL_MAX_FRAMING)
        st_frm_q <= hwdata[3:0];
      if (a_q == `MSL_A_TIMEOUT && hwdata[31:7] == 25'h0 && hwdata[6:0] <= `MSL_MAX_TIMEOUT)
        st_tmo_q <= hwdata[6:0];
      if (a_q == `MSL_A_DELAY) st_dly_q <= hwdata[7:0];
      if (a_q == `MSL_A_ACTION) st_act_q <= hwdata[1:0];
    end
  end

  // Running copy taken once, at the first edge after power-up release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      loaded_q <= 1'b0;
      act_addr_q <= `MSL_RST_STATION;
      act_frm_q <= `MSL_RST_FRAMING;
      act_tmo_q <= `MSL_RST_TIMEOUT;
      act_dly_q <= `MSL_RST_DELAY;
      baud_sel <= `MSL_RST_BAUD;
      loss_action <= `MSL_RST_ACTION;
      ascii_mode <= 1'b0;
      seven_bits <= 1'b0;
      parity <= msl_pkg::MSL_PAR_NONE;
      two_stop <= 1'b0;
    end else if (!loaded_q) begin
      loaded_q <= 1'b1;
      act_addr_q <= st_addr_q;
      act_frm_q <= st_frm_q;
      act_tmo_q <= st_tmo_q;
      act_dly_q <= st_dly_q;
      baud_sel <= st_baud_q;
      loss_action <= st_act_q;
      ascii_mode <= st_frm_q >= `MSL_FIRST_ASCII;
      seven_bits <= st_frm_q >= `MSL_FIRST_7BIT;
      two_stop <= st_frm_q[1:0] == 2'h0;
      case (st_frm_q[1:0])
        2'h2: parity <= msl_pkg::MSL_PAR_EVEN;
        2'h3: parity <= msl_pkg::MSL_PAR_ODD;
        default: parity <= msl_pkg::MSL_PAR_NONE;
      endcase
    end
  end

  // Frame assembly: RTU bytes end on a line gap, ASCII frames on CR LF
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_q <= msl_pkg::MSL_RX_IDLE;
      crc_q <= `MSL_CRC_SEED;
      lrc_q <= 8'h00;
      byte_q <= 8'h00;
      addr_q <= 8'h00;
      fn_q <= 8'h00;
      cnt_q <= 6'h00;
      nib_q <= 1'b0;
      bad_q <= 1'b0;
    end else if (!ascii_mode) begin
      if (rx_gap) begin
        rx_q <= msl_pkg::MSL_RX_IDLE;
        crc_q <= `MSL_CRC_SEED;
        cnt_q <= 6'h00;
        bad_q <= 1'b0;
      end else if (rx_valid) begin
        rx_q <= msl_pkg::MSL_RX_BODY;
        crc_q <= crc_step(crc_q, rx_char);
        if (cnt_q == 6'h00) addr_q <= rx_char;
        if (cnt_q == 6'h01) fn_q <= rx_char;
        if (cnt_q != 6'h3f) cnt_q <= cnt_q + 6'h01;
        bad_q <= bad_q | rx_err;
      end
    end else if (rx_valid) begin
      case (rx_q)
        msl_pkg::MSL_RX_BODY: begin
          if (rx_char == `MSL_CH_CR) begin
            rx_q <= msl_pkg::MSL_RX_LF;
            bad_q <= bad_q | rx_err | nib_q;
          end else if (rx_char == `MSL_CH_COLON) begin
            cnt_q <= 6'h00;
            lrc_q <= 8'h00;
            nib_q <= 1'b0;
            bad_q <= rx_err;
          end else begin
            bad_q <= bad_q | rx_err | hv[4];
            nib_q <= !nib_q;
            if (!nib_q) begin
              byte_q[7:4] <= hv[3:0];
            end else begin
              lrc_q <= lrc_q + abyte;
              if (cnt_q == 6'h00) addr_q <= abyte;
              if (cnt_q == 6'h01) fn_q <= abyte;
              if (cnt_q != 6'h3f) cnt_q <= cnt_q + 6'h01;
            end
          end
        end
        msl_pkg::MSL_RX_LF: rx_q <= msl_pkg::MSL_RX_IDLE;
        default: begin
          if (rx_char == `MSL_CH_COLON) begin
            rx_q <= msl_pkg::MSL_RX_BODY;
            cnt_q <= 6'h00;
            lrc_q <= 8'h00;
            nib_q <= 1'b0;
            bad_q <= rx_err;
          end
        end
      endcase
    end
  end

  // Hex decode, end of frame and its verdict: CRC residue zero, or LRC sum zero after CR LF
  assign hv = hex_val(rx_char);
  assign abyte = {byte_q[7:4], hv[3:0]};
  assign end_p = ascii_mode ? (rx_valid && rx_q == msl_pkg::MSL_RX_LF)
                            : (rx_gap && rx_q == msl_pkg::MSL_RX_BODY);
  assign end_ok = ascii_mode
    ? (rx_char == `MSL_CH_LF && !bad_q && cnt_q >= 6'h03 && lrc_q == 8'h00)
    : (!bad_q && cnt_q >= 6'h04 && crc_q == 16'h0000);

  // Verdict per frame: unicast to others is dropped, broadcast is acted on silently
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_good <= 1'b0;
      func_ok <= 1'b0;
    end else begin
      frame_good <= end_p && end_ok && (addr_q == 8'h00 || addr_q == {3'h0, act_addr_q});
      func_ok <= fn_q == `MSL_FN_READ || fn_q == `MSL_FN_WRITE1 || fn_q == `MSL_FN_LOOP
                 || fn_q == `MSL_FN_WRITEN;
    end
  end

  // Reply delay in milliseconds; a silent station or broadcast never starts it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dly_run_q <= 1'b0;
      dtick_q <= 32'h0;
      dms_q <= 8'h00;
      reply_go <= 1'b0;
    end else begin
      reply_go <= 1'b0;
      if (end_p && end_ok && addr_q != 8'h00 && addr_q == {3'h0, act_addr_q}
          && act_addr_q != 5'h00) begin
        dly_run_q <= 1'b1;
        dtick_q <= 32'h0;
        dms_q <= 8'h00;
      end else if (dly_run_q) begin
        if (dms_q == act_dly_q) begin
          dly_run_q <= 1'b0;
          reply_go <= 1'b1;
        end else if (dtick_q == 32'(MS_CYCLES - 1)) begin
          dtick_q <= 32'h0;
          dms_q <= dms_q + 8'h01;
        end else begin
          dtick_q <= dtick_q + 32'h1;
        end
      end
    end
  end

  // Link-loss watchdog in tenths of a second; good traffic restarts it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_q <= 32'h0;
      tenth_q <= 7'h00;
      comm_fault <= 1'b0;
    end else if (act_tmo_q == 7'h00 || frame_good) begin
      tick_q <= 32'h0;
      tenth_q <= 7'h00;
    end else if (tenth_q == act_tmo_q) begin
      comm_fault <= 1'b1;
    end else if (tick_q == 32'(TENTH_CYCLES - 1)) begin
      tick_q <= 32'h0;
      tenth_q <= tenth_q + 7'h01;
    end else begin
      tick_q <= tick_q + 32'h1;
    end
  end

  // Sticky events, write one to clear; a new event wins over a clear
  assign ev = {end_p && end_ok && !frame_good && addr_q != 8'h00
               && addr_q != {3'h0, act_addr_q},
               !comm_fault && !frame_good && act_tmo_q != 7'h00 && tenth_q == act_tmo_q,
               end_p && !end_ok,
               end_p && end_ok && (addr_q == 8'h00 || addr_q == {3'h0, act_addr_q})};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_st_q <= 4'h0;
      irq_mask_q <= 4'h0;
      irq <= 1'b0;
    end else begin
      irq_st_q <= (irq_st_q & ~((wr_q && a_q == `MSL_A_IRQ_ST) ? hwdata[3:0] : 4'h0)) | ev;
      if (wr_q && a_q == `MSL_A_IRQ_MASK) irq_mask_q <= hwdata[3:0];
      irq <= |(irq_st_q & irq_mask_q);
    end
  end
endmodule // msl_link_config
`default_nettype wire

// file: src/msl_pkg.sv
// Purpose: Types of the Modbus slave link block
// Assumes: Nothing beyond the register header
// Notes: Types only
package msl_pkg;
  typedef enum logic [1:0] {
    MSL_PAR_NONE = 2'b00,
    MSL_PAR_EVEN = 2'b01,
    MSL_PAR_ODD = 2'b10
  } msl_parity_t;
  typedef enum logic [1:0] {
    MSL_RX_IDLE = 2'b00,
    MSL_RX_BODY = 2'b01,
    MSL_RX_LF = 2'b10
  } msl_rx_state_t;
endpackage

// file: src/msl_regs.svh
// Purpose: Register offsets, reset values and timing counts for the Modbus slave link block
// Assumes: 32-bit AHB-Lite, one register per aligned word
// Notes: Definitions only
`ifndef MSL_REGS_SVH
`define MSL_REGS_SVH
`define MSL_A_STATION 8'h00
`define MSL_A_BAUD 8'h04
`define MSL_A_FRAMING 8'h08
`define MSL_A_TIMEOUT 8'h0c
`define MSL_A_DELAY 8'h10
`define MSL_A_ACTION 8'h14
`define MSL_A_ACTIVE 8'h18
`define MSL_A_IRQ_ST 8'h1c
`define MSL_A_IRQ_MASK 8'h20
`define MSL_RST_STATION 5'h01
`define MSL_RST_BAUD 4'h0
`define MSL_RST_FRAMING 4'h1
`define MSL_RST_TIMEOUT 7'h00
`define MSL_RST_DELAY 8'h00
`define MSL_RST_ACTION 2'h0
`define MSL_MAX_STATION 5'h1f
`define MSL_MAX_FRAMING 4'hb
`define MSL_MAX_TIMEOUT 7'h64
`define MSL_FIRST_ASCII 4'h4
`define MSL_FIRST_7BIT 4'h8
`define MSL_CRC_SEED 16'hffff
`define MSL_CRC_POLY 16'ha001
`define MSL_CH_COLON 8'h3a
`define MSL_CH_CR 8'h0d
`define MSL_CH_LF 8'h0a
`define MSL_FN_READ 8'h03
`define MSL_FN_WRITE1 8'h06
`define MSL_FN_LOOP 8'h08
`define MSL_FN_WRITEN 8'h10
`define MSL_CLK_MHZ 200
`define MSL_TENTH_US 100000
`define MSL_MS_US 1000
`define MSL_IRQ_GOOD 0
`define MSL_IRQ_BAD 1
`define MSL_IRQ_LOSS 2
`define MSL_IRQ_DROP 3
`endif

// file: tb/msl_link_config_props.sv
// Purpose: Port assertions for the Modbus slave link configuration block
// Assumes: Bound to every msl_link_config instance, one clock domain
// Notes: Long waits are counted in helper registers, not unrolled
`timescale 1ns/1ps
`default_nettype none
module msl_link_config_chk #(
  parameter int TENTH_CYCLES = 10,
  parameter int MS_CYCLES = 5
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [3:0] baud_sel,
  input wire logic ascii_mode,
  input wire logic seven_bits,
  input wire msl_pkg::msl_parity_t parity,
  input wire logic two_stop,
  input wire logic frame_good,
  input wire logic reply_go,
  input wire logic comm_fault,
  input wire logic [1:0] loss_action
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  localparam int REPLY_MAX = 255 * MS_CYCLES + 8;
  logic [1:0] up_q;
  logic [31:0] since_rst_q;
  logic [31:0] since_good_q;
  wire logic take_req = hsel && hready && htrans[1];
  // Settle counter; the first edge after release reloads the running copy
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      up_q <= 2'h0;
      since_rst_q <= 32'h0;
    end else begin
      if (up_q != 2'h2) up_q <= up_q + 2'h1;
      if (!since_rst_q[31]) since_rst_q <= since_rst_q + 32'h1;
    end
  end
  // Age of the last good frame; starts saturated so a stray reply fails
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) since_good_q <= 32'h8000_0000;
    else if (frame_good) since_good_q <= 32'h1;
    else if (!since_good_q[31]) since_good_q <= since_good_q + 32'h1;
  end
  AST_RUN_STABLE: assert property (up_q == 2'h2 |->
    $stable({baud_sel, ascii_mode, seven_bits, parity, two_stop, loss_action}))
    else $error("running settings changed without a power cycle");
  AST_TWO_STOP: assert property (two_stop |-> parity == msl_pkg::MSL_PAR_NONE)
    else $error("two stop bits with parity");
  AST_SEVEN_ASCII: assert property (seven_bits |-> ascii_mode)
    else $error("seven data bits outside ascii");
  AST_PARITY_CODE: assert property (parity != 2'b11)
    else $error("parity code out of range");
  AST_FAULT_LATE: assert property ($rose(comm_fault) |-> since_rst_q >= TENTH_CYCLES - 1)
    else $error("link fault before one tenth");
  AST_FAULT_STICKY: assert property (comm_fault |=> comm_fault)
    else $error("link fault dropped");
  AST_REPLY_AFTER_GOOD: assert property (reply_go |->
    since_good_q >= 32'h1 && since_good_q <= REPLY_MAX)
    else $error("reply not tied to a good frame");
  AST_GOOD_PULSE: assert property (frame_good |=> !frame_good)
    else $error("good frame pulse too long");
  AST_WRITE_NOWAIT: assert property (take_req && hwrite |=> hreadyout)
    else $error("write stalled");
  AST_READ_WAIT: assert property (take_req && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  cover property (reply_go);
  cover property ($rose(comm_fault));
  cover property (frame_good && !reply_go);
  cover property (frame_good && ascii_mode);
endmodule // msl_link_config_chk
bind msl_link_config msl_link_config_chk #(.TENTH_CYCLES(TENTH_CYCLES), .MS_CYCLES(MS_CYCLES))
  u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .baud_sel(baud_sel), .ascii_mode(ascii_mode),
  .seven_bits(seven_bits), .parity(parity), .two_stop(two_stop), .frame_good(frame_good),
  .reply_go(reply_go), .comm_fault(comm_fault), .loss_action(loss_action));
`default_nettype wire

// file: tb/msl_link_config_tb.sv
// Purpose: Self-checking bench for the Modbus slave link configuration block
// Assumes: Short tenth and millisecond counts set by parameter
// Notes: Register traffic is AHB-Lite single words with a fixed seed
`timescale 1ns/1ps
`default_nettype none
module msl_link_config_tb;
  logic hclk, hresetn, nv_rstn, hsel, hwrite, hreadyout, hresp, rx_valid, rx_err, rx_gap;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, loss_action;
  logic [2:0] hsize;
  logic [7:0] rx_char;
  logic [3:0] baud_sel, bv;
  logic ascii_mode, seven_bits, two_stop, frame_good, func_ok, reply_go, comm_fault, irq;
  logic [4:0] prev;
  msl_pkg::msl_parity_t parity;
  logic [7:0] fns[5] = '{8'h03, 8'h06, 8'h08, 8'h10, 8'h07};
  int errors, total_checks, n_good, n_reply, first_reply;
  msl_link_config #(.TENTH_CYCLES(10), .MS_CYCLES(5)) DUT (.hclk(hclk), .hresetn(hresetn),
    .nv_rstn(nv_rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .rx_valid(rx_valid), .rx_char(rx_char), .rx_err(rx_err), .rx_gap(rx_gap),
    .baud_sel(baud_sel), .ascii_mode(ascii_mode), .seven_bits(seven_bits), .parity(parity),
    .two_stop(two_stop), .frame_good(frame_good), .func_ok(func_ok), .reply_go(reply_go),
    .comm_fault(comm_fault), .loss_action(loss_action), .irq(irq));
  msl_master_model mst (.hclk(hclk), .rx_valid(rx_valid), .rx_char(rx_char), .rx_err(rx_err),
    .rx_gap(rx_gap));
  // Clock, 5 ns period
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic ok, input string what);
    total_checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask
  // Bounded wait for the slave's ready; a hang ends the run
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    if (hreadyout !== 1'b1) begin
      errors++;
      close_out();
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, a};
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask
  // Power cycle: the stored settings survive, the running copy reloads
  task automatic power_cycle;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
  endtask
  // Sends one frame with random data, then counts the pulses that follow
  task automatic frame(input logic [7:0] ad, input logic [7:0] fn, input logic bad, input int w);
    logic [7:0] q[$];
    q = {ad, fn, 8'($urandom), 8'($urandom)};
    if (ascii_mode) mst.send_ascii(q, bad);
    else mst.send(q, bad);
    n_good = 0;
    n_reply = 0;
    first_reply = -1;
    for (int i = 0; i < w; i++) begin
      @(posedge hclk);
      if (frame_good === 1'b1) n_good++;
      if (reply_go === 1'b1 && first_reply < 0) first_reply = i;
      if (reply_go === 1'b1) n_reply++;
    end
  endtask
  // Expected {ascii, seven, parity, two_stop} of a framing code
  function automatic logic [4:0] fexp(input int c);
    logic [1:0] p;
    p = (c % 4 < 2) ? 2'h0 : (c % 4 == 2) ? 2'h1 : 2'h2;
    return {c >= 4, c >= 8, p, c % 4 == 0};
  endfunction
  initial begin
    repeat (100000) @(posedge hclk);
    errors++;
    close_out();
  end
  initial begin
    errors = 0;
    total_checks = 0;
    {hresetn, nv_rstn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    void'($urandom(86192));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    nv_rstn <= 1'b1;
    repeat (2) @(posedge hclk);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, 8'(4 * i), 32'h0);
      check(rd === ((i == 0 || i == 2) ? 32'h1 : 32'h0), "stored reset value");
    end
    bus(1'b0, 8'h24, 32'h0);
    check(rd === 32'h0, "unmapped read");
    check({ascii_mode, seven_bits, parity, two_stop} === fexp(1), "default framing");
    bus(1'b1, 8'h00, 32'h20);
    bus(1'b0, 8'h00, 32'h0);
    check(rd === 32'h1, "station above range kept out");
    bus(1'b1, 8'h00, 32'h1f);
    bus(1'b0, 8'h00, 32'h0);
    check(rd === 32'h1f, "top station stored");
    bus(1'b1, 8'h00, 32'h1);
    foreach (fns[i]) begin
      frame(8'h01, fns[i], 1'b0, 12);
      check(n_good == 1 && n_reply == 1 && func_ok === (i < 4), "own frame");
    end
    frame(8'h01, 8'h03, 1'b1, 12);
    check(n_good == 0 && n_reply == 0, "bad check taken");
    frame(8'h00, 8'h06, 1'b0, 12);
    check(n_good == 1 && n_reply == 0, "broadcast answered");
    bus(1'b1, 8'h20, 32'h8);
    frame(8'h05, 8'h03, 1'b0, 12);
    check(n_good == 0 && n_reply == 0 && irq === 1'b1, "foreign frame");
    bus(1'b1, 8'h1c, 32'h8);
    bus(1'b0, 8'h1c, 32'h0);
    check(rd[3] === 1'b0 && irq === 1'b0, "drop event not cleared");
    bus(1'b1, 8'h10, 32'h2);
    frame(8'h01, 8'h03, 1'b0, 40);
    check(first_reply >= 0 && first_reply <= 3, "delay used before cycle");
    power_cycle();
    frame(8'h01, 8'h06, 1'b0, 40);
    check(n_reply == 1 && first_reply >= 10 && first_reply <= 16, "reply delay");
    bus(1'b1, 8'h00, 32'h0);
    power_cycle();
    frame(8'h00, 8'h03, 1'b0, 40);
    check(n_reply == 0, "silent station replied");
    bus(1'b1, 8'h00, 32'h1);
    prev = fexp(1);
    for (int c = 0; c < 13; c++) begin
      bv = 4'($urandom % 8);
      bus(1'b1, 8'h04, {28'h0, bv});
      bus(1'b1, 8'h08, 32'(c));
      check({ascii_mode, seven_bits, parity, two_stop} === prev, "framing early");
      power_cycle();
      if (c < 12) prev = fexp(c);
      check({ascii_mode, seven_bits, parity, two_stop} === prev, "framing code");
      check(baud_sel === bv, "baud code");
    end
    frame(8'h01, 8'h06, 1'b0, 20);
    check(n_good == 1 && n_reply == 1 && func_ok === 1'b1, "ascii frame");
    frame(8'h01, 8'h03, 1'b1, 20);
    check(n_good == 0 && n_reply == 0, "bad ascii check taken");
    bus(1'b0, 8'h1c, 32'h0);
    check(rd === 32'h3, "frame events");
    bus(1'b1, 8'h0c, 32'h3);
    bus(1'b1, 8'h0c, 32'h65);
    bus(1'b0, 8'h0c, 32'h0);
    check(rd === 32'h3, "timeout above range stored");
    bus(1'b1, 8'h14, 32'h2);
    power_cycle();
    repeat (20) @(posedge hclk);
    check(comm_fault === 1'b0 && loss_action === 2'h2, "early link fault");
    repeat (20) @(posedge hclk);
    check(comm_fault === 1'b1, "missing link fault");
    bus(1'b0, 8'h18, 32'h0);
    check(rd === 32'h0001_b001, "active settings");
    bus(1'b0, 8'h1c, 32'h0);
    check(rd === 32'h4, "loss event");
    bus(1'b1, 8'h0c, 32'h0);
    power_cycle();
    repeat (100) @(posedge hclk);
    check(comm_fault === 1'b0, "fault with zero timeout");
    close_out();
  end
endmodule // msl_link_config_tb
`default_nettype wire

// file: tb/msl_master_model.sv
// Purpose: Behavioural Modbus master feeding decoded RTU and ASCII characters
// Assumes: Called right after a rising edge
// Notes: Only the check bytes can be spoiled on command
`timescale 1ns/1ps
`default_nettype none
module msl_master_model (
  input wire logic hclk,
  output logic rx_valid,
  output logic [7:0] rx_char,
  output logic rx_err,
  output logic rx_gap
);
  initial begin
    rx_valid = 1'b0;
    rx_char = 8'h00;
    rx_err = 1'b0;
    rx_gap = 1'b0;
  end
  // One RTU frame: body, check low byte first, then the silence marker
  task automatic send(input logic [7:0] b[$], input logic bad);
    logic [15:0] crc;
    crc = 16'hffff;
    foreach (b[i]) begin
      crc = crc ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) begin
        crc = crc[0] ? (crc >> 1) ^ 16'ha001 : crc >> 1;
      end
    end
    crc[0] = crc[0] ^ bad;
    b.push_back(crc[7:0]);
    b.push_back(crc[15:8]);
    foreach (b[i]) begin
      rx_valid <= 1'b1;
      rx_char <= b[i];
      @(posedge hclk);
    end
    rx_valid <= 1'b0;
    rx_gap <= 1'b1;
    @(posedge hclk);
    rx_gap <= 1'b0;
    rx_char <= ~rx_char; // Idle line must not look like the last byte
  endtask
  // Upper-case hex character of one nibble
  function automatic logic [7:0] hexc(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction
  // One ASCII frame: colon, two characters per byte high nibble first, LRC, CR LF
  task automatic send_ascii(input logic [7:0] b[$], input logic bad);
    logic [7:0] lrc;
    logic [7:0] c[$];
    lrc = 8'h00;
    foreach (b[i]) lrc = lrc - b[i];
    b.push_back(lrc ^ {7'h00, bad});
    c.push_back(8'h3a);
    foreach (b[i]) begin
      c.push_back(hexc(b[i][7:4]));
      c.push_back(hexc(b[i][3:0]));
    end
    c.push_back(8'h0d);
    c.push_back(8'h0a);
    foreach (c[i]) begin
      rx_valid <= 1'b1;
      rx_char <= c[i];
      @(posedge hclk);
    end
    rx_valid <= 1'b0;
  endtask
endmodule // msl_master_model
`default_nettype wire
